/* File: rtl/fpad_pkg.sv */
// Constants and state encoding of the float add/subtract datapath.
// Assumes a single microcycle clock shared with the host CPU.
package fpad_pkg;
   // Packed operand word layout
   localparam int SIGN_BIT = 31;
   localparam int EXP_MSB = 30;
   localparam int EXP_LSB = 23;
   localparam int MAN_MSB = 22;
   // Internal fraction layout: overflow, hidden, 23+32 bits, 7 guard
   localparam int FRAC_W = 64;
   localparam int OVF_BIT = 63;
   localparam int HID_BIT = 62;
   localparam int MAIN_LSB = 39;
   localparam int EXT_LSB = 7;
   localparam int GUARD_W = 7;
   // Opcodes seen on decode
   localparam logic [1:0] OP_ADD = 2'h0;
   localparam logic [1:0] OP_SUB = 2'h1;
   localparam logic [1:0] OP_POLYNOMIAL = 2'h2;
   localparam logic [1:0] OP_OTHER = 2'h3;
   // Exponent difference thresholds
   localparam logic [7:0] SPEC_DP_DIFF = 8'h07;
   localparam logic [7:0] SPEC_POLYNOMIAL_DP_DIFF = 8'h01;
   localparam logic [7:0] SPEC_POLYNOMIAL_DIFF = 8'h02;
   localparam logic [7:0] NORM_SUB_DIFF = 8'h02;
   localparam logic [7:0] NORM_DP_DIFF = 8'h07;
   localparam logic [7:0] MAX_SHIFT = 8'h3F;
   // Leading-one search limit and exponent range
   localparam logic [5:0] LZ_LIMIT = 6'h3C;
   localparam logic signed [9:0] EXP_MAX = 10'sh0FF;
   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [63:0] RST_FRAC = 64'h0;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_FORK = 4'h1,
      S_CHECK = 4'h2,
      S_NEG = 4'h3,
      S_ALIGN = 4'h4,
      S_ADDSUB = 4'h5,
      S_NORM = 4'h6,
      S_LZ = 4'h7,
      S_ROUND = 4'h8,
      S_PACK = 4'h9,
      S_HOLD = 4'hA
   } fpad_state_t;
endpackage

/* File: rtl/fpad_core.sv */
// Float add/subtract datapath with decode-time operand preload.
// Assumes the CPU shares core_clk and pulses cp_sync once per word.
`timescale 1ns/1ps
module fpad_core (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic decode_valid,
   input wire logic [1:0] op_code,
   input wire logic is_rr,
   input wire logic is_double,
   input wire logic [31:0] gpr_a_word,
   input wire logic [31:0] gpr_b_word,
   input wire logic cp_sync,
   input wire logic [31:0] id_word,
   output logic fp_sync,
   output logic err_sync,
   output logic [31:0] result_word,
   output logic [31:0] result_ext,
   output logic cc_zero,
   output logic cc_neg,
   output logic [47:0] fmul_product,
   output logic [63:0] imul_product
);
   fpad_pkg::fpad_state_t state_r;
   logic [63:0] fa_r, fb_r;
   logic [7:0] ea_r, eb_r;
   logic sign_a_r, sign_b_r;
   logic [23:0] fmc_r, fmp_r;
   logic [31:0] imc_r, imp_r;
   logic [1:0] op_r, slot_r;
   logic dbl_r, rr_r, deferred_r, zres_r, rsign_r;
   logic [64:0] acc_r;
   logic signed [9:0] rexp_r;
   logic [5:0] lz_cnt_r;

   // Exponent compare runs as soon as both exponents are held
   logic a_larger;
   logic [7:0] exp_diff;
   logic [5:0] shamt;
   assign a_larger = ea_r >= eb_r;
   assign exp_diff = a_larger ? ea_r - eb_r : eb_r - ea_r;
   assign shamt = (exp_diff > fpad_pkg::MAX_SHIFT) ? 6'h3F : exp_diff[5:0];

   // Operation class decode
   logic sub_op, polynomial_eval, zero_a, zero_b, rsv, special, slot_ok;
   assign sub_op = (op_r == fpad_pkg::OP_SUB) ? (sign_a_r == sign_b_r)
      : (sign_a_r != sign_b_r);
   assign polynomial_eval = op_r == fpad_pkg::OP_POLYNOMIAL;
   assign zero_a = (ea_r == 8'h00) && !sign_a_r;
   assign zero_b = (eb_r == 8'h00) && !sign_b_r;
   assign rsv = ((ea_r == 8'h00) && sign_a_r)
              || ((eb_r == 8'h00) && sign_b_r);
   assign special = sub_op && ((dbl_r && exp_diff > fpad_pkg::SPEC_DP_DIFF)
      || (polynomial_eval && dbl_r
         && exp_diff > fpad_pkg::SPEC_POLYNOMIAL_DP_DIFF)
      || (polynomial_eval
         && exp_diff < fpad_pkg::SPEC_POLYNOMIAL_DIFF));
   // Slot 0/2 main words skipped for register form, 1/3 ext for single
   assign slot_ok = slot_r[0] ? dbl_r : !rr_r;

   // Unpacked fraction with hidden bit and zero guard bits
   function automatic logic [63:0] expand(input logic [31:0] w);
      expand = {1'b0, 1'b1, w[fpad_pkg::MAN_MSB:0], 32'h0,
                {fpad_pkg::GUARD_W{1'b0}}};
   endfunction

   // Rounding: leading one among four top bits picks round position
   logic neg;
   logic [64:0] mag, rbyte, rnd;
   logic [5:0] rpos;
   always_comb begin
      neg = acc_r[64];
      mag = neg ? 65'h0 - acc_r : acc_r;
      if (mag[fpad_pkg::OVF_BIT]) begin
         rpos = dbl_r ? 6'h07 : 6'h27;
      end else if (mag[fpad_pkg::HID_BIT]) begin
         rpos = dbl_r ? 6'h06 : 6'h26;
      end else if (mag[61]) begin
         rpos = dbl_r ? 6'h05 : 6'h25;
      end else begin
         rpos = dbl_r ? 6'h04 : 6'h24;
      end
      rbyte = 65'h1 << rpos;
      rnd = neg ? rbyte - acc_r : acc_r + rbyte;
   end

   // Sequencer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= fpad_pkg::S_IDLE;
         slot_r <= 2'h0;
      end else begin
         case (state_r)
            fpad_pkg::S_IDLE: begin
               if (decode_valid && op_code != fpad_pkg::OP_OTHER) begin
                  slot_r <= 2'h0;
                  if (is_rr && !is_double) begin
                     state_r <= fpad_pkg::S_CHECK;
                  end else begin
                     state_r <= fpad_pkg::S_FORK;
                  end
               end
            end
            fpad_pkg::S_FORK: begin
               if (!slot_ok || cp_sync) begin
                  slot_r <= slot_r + 2'h1;
                  if (slot_r == 2'h3) begin
                     state_r <= fpad_pkg::S_CHECK;
                  end
               end
            end
            fpad_pkg::S_CHECK: begin
               if (rsv) begin
                  state_r <= fpad_pkg::S_IDLE;
               end else if (zero_a || zero_b) begin
                  state_r <= fpad_pkg::S_PACK;
               end else if (special) begin
                  state_r <= fpad_pkg::S_NEG;
               end else begin
                  state_r <= fpad_pkg::S_ALIGN;
               end
            end
            fpad_pkg::S_NEG: state_r <= fpad_pkg::S_ALIGN;
            fpad_pkg::S_ALIGN: state_r <= fpad_pkg::S_ADDSUB;
            fpad_pkg::S_ADDSUB: state_r <= fpad_pkg::S_NORM;
            fpad_pkg::S_NORM: begin
               // Deferred pass, then zero, then close subtract
               if (deferred_r) begin
                  state_r <= fpad_pkg::S_NORM;
               end else if (acc_r == 65'h0) begin
                  state_r <= fpad_pkg::S_PACK;
               end else if (sub_op && exp_diff < fpad_pkg::NORM_SUB_DIFF) begin
                  state_r <= fpad_pkg::S_LZ;
               end else begin
                  state_r <= fpad_pkg::S_ROUND;
               end
            end
            fpad_pkg::S_LZ: begin
               if (acc_r[fpad_pkg::HID_BIT] || acc_r[fpad_pkg::OVF_BIT]
                   || lz_cnt_r == fpad_pkg::LZ_LIMIT) begin
                  state_r <= fpad_pkg::S_ROUND;
               end
            end
            fpad_pkg::S_ROUND: state_r <= fpad_pkg::S_PACK;
            fpad_pkg::S_PACK: state_r <= fpad_pkg::S_HOLD;
            fpad_pkg::S_HOLD: begin
               if (cp_sync) begin
                  state_r <= fpad_pkg::S_IDLE;
               end
            end
            default: state_r <= fpad_pkg::S_IDLE;
         endcase
      end
   end

   // Operand registers: preload in idle, fork overwrite, alignment
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fa_r <= fpad_pkg::RST_FRAC;
         fb_r <= fpad_pkg::RST_FRAC;
         ea_r <= 8'h00;
         eb_r <= 8'h00;
         sign_a_r <= 1'b0;
         sign_b_r <= 1'b0;
         op_r <= fpad_pkg::OP_ADD;
         dbl_r <= 1'b0;
         rr_r <= 1'b0;
      end else if (state_r == fpad_pkg::S_IDLE) begin
         fa_r <= expand(gpr_a_word);
         fb_r <= expand(gpr_b_word);
         ea_r <= gpr_a_word[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB];
         eb_r <= gpr_b_word[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB];
         sign_a_r <= gpr_a_word[fpad_pkg::SIGN_BIT];
         sign_b_r <= gpr_b_word[fpad_pkg::SIGN_BIT];
         op_r <= op_code;
         dbl_r <= is_double;
         rr_r <= is_rr;
      end else if (state_r == fpad_pkg::S_FORK && slot_ok && cp_sync) begin
         case (slot_r)
            2'h0: begin
               fa_r <= expand(id_word);
               ea_r <= id_word[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB];
               sign_a_r <= id_word[fpad_pkg::SIGN_BIT];
            end
            2'h1: fa_r[38:fpad_pkg::EXT_LSB] <= id_word;
            2'h2: begin
               fb_r <= expand(id_word);
               eb_r <= id_word[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB];
               sign_b_r <= id_word[fpad_pkg::SIGN_BIT];
            end
            default: fb_r[38:fpad_pkg::EXT_LSB] <= id_word;
         endcase
      end else if (state_r == fpad_pkg::S_NEG) begin
         // Complement written back into its own register
         if (a_larger) begin
            fb_r <= 64'h0 - fb_r;
         end else begin
            fa_r <= 64'h0 - fa_r;
         end
      end else if (state_r == fpad_pkg::S_ALIGN) begin
         // Guard bits catch what falls off the right end
         if (a_larger) begin
            fb_r <= special ? 64'($signed(fb_r) >>> shamt)
                            : fb_r >> shamt;
         end else begin
            fa_r <= special ? 64'($signed(fa_r) >>> shamt)
                            : fa_r >> shamt;
         end
      end
   end

   // Multiply operand registers; float product starts in idle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fmc_r <= 24'h0;
         fmp_r <= 24'h0;
         imc_r <= 32'h0;
         imp_r <= 32'h0;
         fmul_product <= 48'h0;
         imul_product <= 64'h0;
      end else begin
         if (state_r == fpad_pkg::S_IDLE) begin
            fmc_r <= {1'b1, gpr_a_word[fpad_pkg::MAN_MSB:0]};
            imp_r <= gpr_a_word;
            fmp_r <= {1'b1, gpr_b_word[fpad_pkg::MAN_MSB:0]};
            imc_r <= gpr_b_word;
            fmul_product <= fmc_r * fmp_r;
         end
         imul_product <= imc_r * imp_r;
      end
   end

   // Fraction accumulator, result exponent and sign
   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_r <= 65'h0;
         rexp_r <= 10'sh000;
         rsign_r <= 1'b0;
         deferred_r <= 1'b0;
         zres_r <= 1'b0;
         lz_cnt_r <= 6'h0;
      end else begin
         case (state_r)
            fpad_pkg::S_CHECK: begin
               deferred_r <= 1'b0;
               zres_r <= zero_a && zero_b;
               if (zero_a) begin
                  acc_r <= {1'b0, fb_r};
                  rexp_r <= {2'b00, eb_r};
                  rsign_r <= sign_b_r ^ (op_r == fpad_pkg::OP_SUB);
               end else begin
                  acc_r <= {1'b0, fa_r};
                  rexp_r <= {2'b00, ea_r};
                  rsign_r <= sign_a_r;
               end
            end
            fpad_pkg::S_ADDSUB: begin
               rexp_r <= {2'b00, a_larger ? ea_r : eb_r};
               // Deferred flow forms larger minus smaller, so the sign
               // flips when the first operand is the smaller one
               rsign_r <= sign_a_r ^ (special && !a_larger);
               if (special) begin
                  deferred_r <= 1'b1;
                  acc_r <= {1'b0, a_larger ? fa_r : fb_r};
               end else if (sub_op) begin
                  acc_r <= {fa_r[63], fa_r} - {fb_r[63], fb_r};
               end else begin
                  acc_r <= {fa_r[63], fa_r} + {fb_r[63], fb_r};
               end
            end
            fpad_pkg::S_NORM: begin
               lz_cnt_r <= 6'h0;
               if (deferred_r) begin
                  // Smaller operand already negated, so add
                  acc_r <= {fa_r[63], fa_r} + {fb_r[63], fb_r};
                  deferred_r <= 1'b0;
               end else if (acc_r == 65'h0) begin
                  zres_r <= 1'b1;
               end else if (sub_op && exp_diff < fpad_pkg::NORM_SUB_DIFF) begin
                  acc_r <= mag;
                  rsign_r <= rsign_r ^ neg;
               end
            end
            fpad_pkg::S_LZ: begin
               if (!acc_r[fpad_pkg::HID_BIT] && !acc_r[fpad_pkg::OVF_BIT]) begin
                  if (lz_cnt_r == fpad_pkg::LZ_LIMIT) begin
                     zres_r <= 1'b1;
                  end else begin
                     acc_r <= acc_r << 1;
                     lz_cnt_r <= lz_cnt_r + 6'h1;
                     rexp_r <= rexp_r - 10'sh001;
                  end
               end
            end
            fpad_pkg::S_ROUND: begin
               rsign_r <= rsign_r ^ neg;
               if (rnd[fpad_pkg::OVF_BIT]) begin
                  acc_r <= rnd >> 1;
                  rexp_r <= rexp_r + 10'sh001;
               end else if (rnd[fpad_pkg::HID_BIT]) begin
                  acc_r <= rnd;
               end else if (rnd[61]) begin
                  acc_r <= rnd << 1;
                  rexp_r <= rexp_r - 10'sh001;
               end else begin
                  acc_r <= rnd << 2;
                  rexp_r <= rexp_r - 10'sh002;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Host handshake and packed result on bus A
   logic ovf, unf;
   logic [31:0] bus_a;
   assign ovf = rexp_r > fpad_pkg::EXP_MAX;
   assign unf = rexp_r <= 10'sh000;
   assign bus_a = {rsign_r, rexp_r[7:0],
                   acc_r[61:fpad_pkg::MAIN_LSB]};
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fp_sync <= 1'b0;
         err_sync <= 1'b0;
         result_word <= fpad_pkg::RST_WORD;
         result_ext <= fpad_pkg::RST_WORD;
         cc_zero <= 1'b0;
         cc_neg <= 1'b0;
      end else begin
         case (state_r)
            fpad_pkg::S_FORK: fp_sync <= slot_ok && cp_sync;
            fpad_pkg::S_CHECK: begin
               fp_sync <= 1'b0;
               err_sync <= rsv;
            end
            fpad_pkg::S_PACK: begin
               fp_sync <= 1'b1;
               if (zres_r || unf) begin
                  result_word <= fpad_pkg::RST_WORD;
                  result_ext <= fpad_pkg::RST_WORD;
                  cc_zero <= 1'b1;
                  cc_neg <= 1'b0;
                  err_sync <= !zres_r;
               end else if (ovf) begin
                  result_word <= 32'h8000_0000; // Reserved code
                  result_ext <= fpad_pkg::RST_WORD;
                  cc_zero <= 1'b0;
                  cc_neg <= 1'b0;
                  err_sync <= 1'b1;
               end else begin
                  result_word <= bus_a;
                  result_ext <= acc_r[38:fpad_pkg::EXT_LSB];
                  cc_zero <= 1'b0;
                  cc_neg <= rsign_r;
                  err_sync <= 1'b0;
               end
            end
            fpad_pkg::S_HOLD: begin
               if (cp_sync) begin
                  fp_sync <= 1'b0;
                  err_sync <= 1'b0;
               end
            end
            default: begin
               fp_sync <= 1'b0;
               err_sync <= 1'b0;
            end
         endcase
      end
   end

   // Checks
   property p_preload;
      @(posedge core_clk) disable iff (rst)
      state_r == fpad_pkg::S_IDLE |=> ea_r == $past(gpr_a_word[30:23])
         && eb_r == $past(gpr_b_word[30:23])
         && sign_b_r == $past(gpr_b_word[31]);
   endproperty
   a_preload: assert property (p_preload) else $error("preload");
   property p_dispatch;
      @(posedge core_clk) disable iff (rst)
      state_r == fpad_pkg::S_IDLE && decode_valid && is_rr && !is_double
         && op_code != fpad_pkg::OP_OTHER |=> state_r == fpad_pkg::S_CHECK;
   endproperty
   a_dispatch: assert property (p_dispatch) else $error("dispatch");
   property p_special;
      @(posedge core_clk) disable iff (rst)
      state_r == fpad_pkg::S_CHECK && special && !rsv && !zero_a && !zero_b
         |=> state_r == fpad_pkg::S_NEG ##1 state_r == fpad_pkg::S_ALIGN;
   endproperty
   a_special: assert property (p_special) else $error("special");
   property p_rexp;
      @(posedge core_clk) disable iff (rst)
      state_r == fpad_pkg::S_ADDSUB |=> rexp_r[7:0] ==
         $past(a_larger ? ea_r : eb_r);
   endproperty
   a_rexp: assert property (p_rexp) else $error("exponent");
   property p_lz;
      @(posedge core_clk) disable iff (rst) lz_cnt_r <= fpad_pkg::LZ_LIMIT;
   endproperty
   a_lz: assert property (p_lz) else $error("shift limit");
   property p_zero;
      @(posedge core_clk) disable iff (rst)
      state_r == fpad_pkg::S_PACK && zres_r
         |=> fp_sync && cc_zero && !err_sync && result_word[31:23] == 9'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("exact zero");
   property p_rsv;
      @(posedge core_clk) disable iff (rst)
      state_r == fpad_pkg::S_CHECK && rsv
         |=> err_sync && !fp_sync && state_r == fpad_pkg::S_IDLE;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved");
   property p_hold;
      @(posedge core_clk) disable iff (rst)
      state_r == fpad_pkg::S_HOLD && !cp_sync
         |=> fp_sync && $stable(result_word) && state_r == fpad_pkg::S_HOLD;
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_alu;
      @(posedge core_clk) disable iff (rst)
      state_r == fpad_pkg::S_ADDSUB && !special && !sub_op
         |=> acc_r == $past({fa_r[63], fa_r} + {fb_r[63], fb_r});
   endproperty
   a_alu: assert property (p_alu) else $error("fraction add");
   c_lz: cover property (@(posedge core_clk) state_r == fpad_pkg::S_LZ);
   c_def: cover property (@(posedge core_clk) deferred_r);
   c_hold: cover property (@(posedge core_clk)
      state_r == fpad_pkg::S_HOLD && cp_sync);
endmodule

/* File: bench/fpad_cpu_model.sv */
// Host CPU stand-in: hands operand words over the sync pair, acks results.
// Assumes it shares core_clk with the datapath and is driven by the bench.
`timescale 1ns/1ps
module fpad_cpu_model (
   input wire logic core_clk,
   input wire logic fp_sync,
   output logic cp_sync,
   output logic [31:0] id_word
);
   logic [31:0] last_r;
   // Bus idles with a pattern unlike any operand
   initial begin
      cp_sync = 1'b0;
      last_r = 32'h00000000;
      id_word = 32'hFFFFFFFF;
   end
   // One word per pulse; released bus shows the inverse, not a stale copy
   task automatic send_word(input logic [31:0] w, output logic taken);
      @(posedge core_clk);
      #1;
      cp_sync = 1'b1;
      id_word = w;
      last_r = w;
      @(posedge core_clk);
      #1;
      cp_sync = 1'b0;
      id_word = ~last_r;
      taken = fp_sync;
   endtask
   // Bounded wait so a silent datapath cannot hang the model
   task automatic wait_result(output logic got);
      got = 1'b0;
      for (int i = 0; i < 200 && !got; i++) begin
         @(posedge core_clk);
         #1;
         got = fp_sync;
      end
   endtask
   // Result taken: one sync pulse
   task automatic ack();
      @(posedge core_clk);
      #1;
      cp_sync = 1'b1;
      @(posedge core_clk);
      #1;
      cp_sync = 1'b0;
   endtask
endmodule

/* File: bench/fpad_core_tb.sv */
// Self-checking bench for the float add/subtract datapath.
// Assumes the CPU model drives cp_sync of the operand sync pair and the id bus.
`timescale 1ns/1ps
module fpad_core_tb;
   typedef struct {
      logic [31:0] a, b, r;
      logic [1:0] op;
      logic [2:0] f;
   } fpad_row_t;
   logic core_clk = 1'b0;
   logic rst, decode_valid, is_rr, is_double, cp_sync, flag;
   logic fp_sync, err_sync, cc_zero, cc_neg;
   logic [1:0] op_code;
   logic [31:0] gpr_a_word, gpr_b_word, id_word, result_word, result_ext;
   logic [47:0] fmul_product;
   logic [63:0] imul_product;
   int miscompares = 0;
   int compares = 0;
   fpad_row_t rows [11];

   // 50 MHz microcycle clock
   always #10 core_clk = ~core_clk;

   fpad_core DUT (.core_clk(core_clk), .rst(rst),
      .decode_valid(decode_valid), .op_code(op_code), .is_rr(is_rr),
      .is_double(is_double), .gpr_a_word(gpr_a_word),
      .gpr_b_word(gpr_b_word), .cp_sync(cp_sync), .id_word(id_word),
      .fp_sync(fp_sync), .err_sync(err_sync), .result_word(result_word),
      .result_ext(result_ext), .cc_zero(cc_zero), .cc_neg(cc_neg),
      .fmul_product(fmul_product), .imul_product(imul_product));
   fpad_cpu_model cpu (.core_clk(core_clk), .fp_sync(fp_sync),
      .cp_sync(cp_sync), .id_word(id_word));

   // Case equality so an unknown never passes
   task automatic chk(input string nm, input logic [63:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Decode is a one-cycle strobe
   task automatic decode(input logic [1:0] op, input logic rr, dbl);
      @(posedge core_clk);
      #1;
      decode_valid = 1'b1;
      op_code = op;
      is_rr = rr;
      is_double = dbl;
      @(posedge core_clk);
      #1;
      decode_valid = 1'b0;
   endtask
   // Words go in fork slot order: A main, A ext, B main, B ext
   task automatic run_op(input logic [1:0] op, input logic rr, dbl,
      input logic [127:0] ws, input int nw);
      logic t;
      decode(op, rr, dbl);
      for (int i = 0; i < nw; i++) begin
         cpu.send_word(ws[127-32*i -: 32], t);
         chk("word taken", 64'(t), 64'h1);
      end
      cpu.wait_result(t);
      chk("result ready", 64'(t), 64'h1);
   endtask
   // Stall the ack a little to see the result stand
   task automatic finish_op(input logic [31:0] r, input logic [2:0] f);
      chk("result", 64'(result_word), 64'(r));
      chk("zero cc", 64'(cc_zero), 64'(f[2]));
      chk("neg cc", 64'(cc_neg), 64'(f[1]));
      chk("error sync", 64'(err_sync), 64'(f[0]));
      repeat (2) @(posedge core_clk);
      #1;
      chk("result held", 64'(fp_sync), 64'h1);
      cpu.ack();
      chk("result dropped", 64'(fp_sync), 64'h0);
   endtask

   // Cut a hang short; the whole run needs well under 2000 cycles
   initial begin
      #100000;
      miscompares++;
      finish_test();
   end

   // Reset, table of register-register cases, then awkward cases
   initial begin
      rst = 1'b1;
      decode_valid = 1'b0;
      op_code = 2'h0;
      is_rr = 1'b1;
      is_double = 1'b0;
      gpr_a_word = 32'h00000000;
      gpr_b_word = 32'h00000000;
      rows = '{'{32'h40800000, 32'h40800000, 32'h41000000, 2'h0, 3'h0},
         '{32'h41400000, 32'h40800000, 32'h41000000, 2'h1, 3'h0},
         '{32'h40800000, 32'hC0800000, 32'h00000000, 2'h0, 3'h4},
         '{32'h40800000, 32'hC0800000, 32'h41000000, 2'h1, 3'h0},
         '{32'h00000000, 32'h41400000, 32'h41400000, 2'h0, 3'h0},
         '{32'h00000000, 32'h41400000, 32'hC1400000, 2'h1, 3'h2},
         '{32'h40800000, 32'h41000000, 32'h41400000, 2'h2, 3'h0},
         '{32'h41000000, 32'h41400000, 32'hC0800000, 2'h1, 3'h2},
         '{32'h42000000, 32'h40800000, 32'h41E00000, 2'h1, 3'h0},
         '{32'h00A00000, 32'h00800000, 32'h00000000, 2'h1, 3'h5},
         '{32'h7F800000, 32'h7F800000, 32'h80000000, 2'h0, 3'h1}};
      repeat (3) @(posedge core_clk);
      #1;
      rst = 1'b0;
      chk("reset sync", 64'(fp_sync), 64'h0);
      $display("reset done");
      foreach (rows[k]) begin
         gpr_a_word = rows[k].a;
         gpr_b_word = rows[k].b;
         run_op(rows[k].op, 1'b1, 1'b0, 128'h0, 0);
         finish_op(rows[k].r, rows[k].f);
         $display("row %0d done", k);
      end
      // Reset while a result stands drops the sync and clears the word
      gpr_a_word = 32'h40800000;
      gpr_b_word = 32'h40800000;
      run_op(2'h0, 1'b1, 1'b0, 128'h0, 0);
      rst = 1'b1;
      @(posedge core_clk);
      #1;
      rst = 1'b0;
      chk("mid reset sync", 64'(fp_sync), 64'h0);
      chk("mid reset word", 64'(result_word), 64'h0);
      $display("mid-run reset done");
      // Fetched double operands replace the preloaded copies
      gpr_a_word = 32'h3F000000;
      gpr_b_word = 32'hC2C00000;
      run_op(2'h0, 1'b0, 1'b1,
         128'h40800000_00000001_40800000_00000001, 4);
      chk("double ext", 64'(result_ext), 64'h1);
      finish_op(32'h41000000, 3'h0);
      $display("double fetch done");
      // Fetched single operands use the two main slots only
      run_op(2'h1, 1'b0, 1'b0,
         128'h41400000_40800000_00000000_00000000, 2);
      finish_op(32'h41000000, 3'h0);
      $display("single fetch done");
      // Wide double subtract takes the complement-first path
      gpr_a_word = 32'h44800000;
      gpr_b_word = 32'h40800000;
      run_op(2'h1, 1'b1, 1'b1, 128'h0, 2);
      chk("special ext", 64'(result_ext), 64'h0);
      finish_op(32'h447F0000, 3'h0);
      // Same flow with the smaller operand first gives a negative result
      gpr_a_word = 32'h40800000;
      gpr_b_word = 32'h44800000;
      run_op(2'h1, 1'b1, 1'b1, 128'h0, 2);
      finish_op(32'hC47F0000, 3'h2);
      $display("special flow done");
      // Minus zero aborts with error sync alone
      gpr_a_word = 32'h80000000;
      decode(2'h0, 1'b1, 1'b0);
      flag = 1'b0;
      for (int i = 0; i < 20 && !flag; i++) begin
         @(posedge core_clk);
         #1;
         flag = err_sync;
      end
      chk("reserved err", 64'(flag), 64'h1);
      chk("reserved sync", 64'(fp_sync), 64'h0);
      $display("reserved operand done");
      // Ignored opcode leaves the idle preload running
      gpr_a_word = 32'h40800003;
      gpr_b_word = 32'h40800005;
      decode(2'h3, 1'b1, 1'b0);
      flag = 1'b0;
      repeat (10) begin
         @(posedge core_clk);
         #1;
         flag = flag | fp_sync;
      end
      chk("ignored op", 64'(flag), 64'h0);
      chk("float product", 64'(fmul_product), 64'h40000400000F);
      chk("int product", imul_product, 64'h104040020400000F);
      $display("preload products done");
      finish_test();
   end
endmodule
